// [bsd_pin_sync.sv]
package bsd_pkg;

	// Clock rate and the derived one millisecond tick
	localparam int CLOCK_KHZ        = 125_000;            // 125 MHz system clock
	localparam int TICK_MS          = 1;                  // Watchdog tick period, ms
	localparam int TICK_CYCLES      = TICK_MS * CLOCK_KHZ; // Cycles per watchdog tick
	localparam int TIMEOUT_MS       = 5000;               // Stuck state machine limit, ms

	// Strap pin widths
	localparam int TD_WIDTH         = 16;                 // Shared strap / LED pins
	localparam int PD_WIDTH         = 9;                  // Clock tuning strap pins
	localparam int DELAY_W          = 3;                  // One clock tuning field
	localparam int DELAY_FIELDS     = 3;                  // Bank A, bank B, database

	// Strap bit positions on the shared pins
	localparam int TD_MODULE_DETECT = 3;
	localparam int TD_DB_SRAM_SIZE  = 5;
	localparam int TD_FDB_DEPTH     = 7;
	localparam int TD_EEPROM        = 8;
	localparam int TD_MCT_AGING     = 9;
	localparam int TD_FCB_AGING     = 10;
	localparam int TD_TIMEOUT_EN    = 11;
	localparam int TD_SELFTEST      = 15;

	// Buffer memory size codes
	localparam logic [1:0] BUF_512K = 2'h0;
	localparam logic [1:0] BUF_1M   = 2'h1;
	localparam logic [1:0] BUF_2M   = 2'h2;

	// Clock tuning code that defers to the register field
	localparam logic [2:0] DELAY_FROM_REG = 3'h0;
	localparam logic [2:0] DELAY_ONE      = 3'h1;

	// Register byte addresses
	localparam logic [7:0] ADDR_CONFIG    = 8'h00; // Decoded configuration, read only
	localparam logic [7:0] ADDR_STRAP_RAW = 8'h04; // Captured strap levels, read only
	localparam logic [7:0] ADDR_BANK_CLK  = 8'h08; // Bank clock delay control
	localparam logic [7:0] ADDR_DB_CLK    = 8'h0C; // Database clock delay control
	localparam logic [7:0] ADDR_DELAY_ST  = 8'h10; // Effective delay selection

	// Field positions
	localparam int BANK_A_LSB       = 0;  // Bank A field in bank clock control
	localparam int BANK_B_LSB       = 4;  // Bank B field in bank clock control
	localparam int DB_LSB           = 0;  // Field in database clock control
	localparam int RAW_PD_LSB       = 16; // Tuning straps in raw strap word
	localparam int RAW_BANK_A       = 25;
	localparam int RAW_BANK_B       = 26;
	localparam int ST_FROM_REG_LSB  = 12; // From-register flags in delay status

	// Configuration word bit positions
	localparam int CFG_MODULE_DETECT = 0;
	localparam int CFG_DB_512K       = 1;
	localparam int CFG_FDB_SINGLE    = 2;
	localparam int CFG_BUF_LSB       = 4;
	localparam int CFG_EEPROM        = 6;
	localparam int CFG_MCT_AGING     = 7;
	localparam int CFG_FCB_AGING     = 8;
	localparam int CFG_TIMEOUT_EN    = 9;
	localparam int CFG_SELFTEST      = 10;

	// Register reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

endpackage : bsd_pkg

// Two flip-flop synchroniser for pins from outside the clock domain
module bsd_pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic [WIDTH-1:0] pins_async,
	output logic      [WIDTH-1:0] pins_sync
);

	logic [WIDTH-1:0] meta_reg; // First stage, read only by the second

	// Both stages register the pins without reset
	always_ff @(posedge clock) begin
		meta_reg  <= pins_async;
		pins_sync <= meta_reg;
	end

endmodule : bsd_pin_sync

// [bsd_strap_decoder.sv]
// Summary of operation
// - Strap bit 3 low enables module detection
// - Strap bit 5 low selects 512K database
// - Strap bit 7 high means single layer
// - Bank straps 11/10/0x select 2M/1M/512K
// - Strap bit 8 low means EEPROM present
// - Strap bit 9 high enables table aging
// - Strap bit 10 high enables handle aging
// - Strap bit 11 enables 5 s stuck reset
// - Strap bit 15 low loops RAM self-test
// - Tuning code zero defers to register field
// - Codes 1..7 select delay methods 0..6
// - Bank B field uses bank A meanings
// - Database code zero uses database register
// - Shared pins become LED outputs after reset
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
module bsd_strap_decoder #(
	parameter int SM_COUNT        = 4,                      // Watched state machines
	parameter int TICK_CYCLES     = bsd_pkg::TICK_CYCLES,   // Cycles per millisecond tick
	parameter int TIMEOUT_TICKS   = bsd_pkg::TIMEOUT_MS     // Ticks before timeout reset
) (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	input  wire logic [15:0]             strap_td_in,
	input  wire logic [8:0]              strap_pd_in,
	input  wire logic                    bank_a_top_address_strap,
	input  wire logic                    bank_b_top_address_strap,
	input  wire logic [15:0]             led_data,
	output logic      [15:0]             strap_td_out,
	output logic                         strap_td_oe,
	input  wire logic [SM_COUNT-1:0]     sm_idle,
	output logic                         module_detect_en,
	output logic                         db_sram_512k,
	output logic                         fdb_single_layer,
	output logic      [1:0]              buffer_size,
	output logic                         eeprom_present,
	output logic                         multicast_control_table_aging_en,
	output logic                         frame_control_buffer_aging_en,
	output logic                         timeout_reset_en,
	output logic                         ram_selftest_loop,
	output logic      [2:0]              clock_delay_from_reg,
	output logic      [8:0]              clock_delay_method,
	output logic                         timeout_reset
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);   // Tick divider width
	localparam int CNT_W  = $clog2(TIMEOUT_TICKS + 1); // Per machine counter width

	// Refuse settings the counters cannot serve
	if (SM_COUNT < 1 || TICK_CYCLES < 1 || TIMEOUT_TICKS < 1) begin : g_bad_param
		$error("bsd_strap_decoder: counts must be at least one");
	end

	// Synchronised strap pins
	logic [15:0] td_sync;          // Shared pins after two flops
	logic [10:0] misc_sync;        // Tuning and bank straps after two flops

	bsd_pin_sync #(.WIDTH(16)) u_td_sync (
		.clock      (clock),
		.pins_async (strap_td_in),
		.pins_sync  (td_sync)
	);

	bsd_pin_sync #(.WIDTH(11)) u_misc_sync (
		.clock      (clock),
		.pins_async ({bank_b_top_address_strap, bank_a_top_address_strap, strap_pd_in}),
		.pins_sync  (misc_sync)
	);

	// Captured straps and decoded configuration
	logic [15:0] td_cap_reg,  td_cap_next;   // Shared pin levels at release
	logic [10:0] misc_cap_reg, misc_cap_next; // Tuning and bank levels at release
	logic        mod_det_reg, mod_det_next;
	logic        db512_reg,   db512_next;
	logic        fdb1_reg,    fdb1_next;
	logic [1:0]  buf_reg,     buf_next;
	logic        eeprom_reg,  eeprom_next;
	logic        mct_reg,     mct_next;
	logic        fcb_reg,     fcb_next;
	logic        tmo_en_reg,  tmo_en_next;
	logic        loop_reg,    loop_next;

	// Follow the pins while reset is held; the last sample is kept
	always_comb begin
		td_cap_next   = td_cap_reg;
		misc_cap_next = misc_cap_reg;
		mod_det_next  = mod_det_reg;
		db512_next    = db512_reg;
		fdb1_next     = fdb1_reg;
		buf_next      = buf_reg;
		eeprom_next   = eeprom_reg;
		mct_next      = mct_reg;
		fcb_next      = fcb_reg;
		tmo_en_next   = tmo_en_reg;
		loop_next     = loop_reg;
		if (rst) begin
			td_cap_next   = td_sync;
			misc_cap_next = misc_sync;
			mod_det_next  = !td_sync[bsd_pkg::TD_MODULE_DETECT];
			db512_next    = !td_sync[bsd_pkg::TD_DB_SRAM_SIZE];
			fdb1_next     = td_sync[bsd_pkg::TD_FDB_DEPTH];
			eeprom_next   = !td_sync[bsd_pkg::TD_EEPROM];
			mct_next      = td_sync[bsd_pkg::TD_MCT_AGING];
			fcb_next      = td_sync[bsd_pkg::TD_FCB_AGING];
			tmo_en_next   = td_sync[bsd_pkg::TD_TIMEOUT_EN];
			loop_next     = !td_sync[bsd_pkg::TD_SELFTEST];
			// Bank A strap picks the large sizes, bank B the step
			case (misc_sync[10:9])
				2'b11:   buf_next = bsd_pkg::BUF_2M;
				2'b01:   buf_next = bsd_pkg::BUF_1M;
				default: buf_next = bsd_pkg::BUF_512K;
			endcase
		end
	end

	// Register the capture
	always_ff @(posedge clock) begin
		td_cap_reg   <= td_cap_next;
		misc_cap_reg <= misc_cap_next;
		mod_det_reg  <= mod_det_next;
		db512_reg    <= db512_next;
		fdb1_reg     <= fdb1_next;
		buf_reg      <= buf_next;
		eeprom_reg   <= eeprom_next;
		mct_reg      <= mct_next;
		fcb_reg      <= fcb_next;
		tmo_en_reg   <= tmo_en_next;
		loop_reg     <= loop_next;
	end

	assign module_detect_en                 = mod_det_reg;
	assign db_sram_512k                     = db512_reg;
	assign fdb_single_layer                 = fdb1_reg;
	assign buffer_size                      = buf_reg;
	assign eeprom_present                   = eeprom_reg;
	assign multicast_control_table_aging_en = mct_reg;
	assign frame_control_buffer_aging_en    = fcb_reg;
	assign timeout_reset_en                 = tmo_en_reg;
	assign ram_selftest_loop                = loop_reg;

	// Shared pins: inputs in reset, LED outputs afterwards
	logic [15:0] led_out_next;
	logic        led_oe_next;

	always_comb begin
		led_out_next = rst ? 16'h0000 : led_data;
		led_oe_next  = !rst;
	end

	always_ff @(posedge clock) begin
		strap_td_out <= led_out_next;
		strap_td_oe  <= led_oe_next;
	end

	// Bus slave state
	logic [31:0] bank_clk_reg, bank_clk_next; // Bank clock delay control
	logic [31:0] db_clk_reg,   db_clk_next;   // Database clock delay control
	logic        wr_pend_reg,  wr_pend_next;  // Write data phase follows
	logic [7:0]  wr_addr_reg,  wr_addr_next;  // Byte address of that write
	logic [31:0] rdata_next;
	logic        addr_phase;                  // Valid transfer taken this edge
	logic [31:0] delay_status;                // Effective delay word

	assign addr_phase = hsel && htrans[1] && hready;

	// Decode writes in the data phase, read data from the coming state
	always_comb begin
		bank_clk_next = bank_clk_reg;
		db_clk_next   = db_clk_reg;
		wr_pend_next  = addr_phase && hwrite;
		wr_addr_next  = addr_phase ? haddr[7:0] : wr_addr_reg;
		rdata_next    = 32'h0000_0000;
		if (wr_pend_reg && haddr[31:8] == 24'h00_0000) begin
			case (wr_addr_reg)
				bsd_pkg::ADDR_BANK_CLK: bank_clk_next = hwdata & 32'h0000_0077;
				bsd_pkg::ADDR_DB_CLK:   db_clk_next   = hwdata & 32'h0000_0007;
				default:                ; // Read-only or unmapped: ignored
			endcase
		end
		if (rst) begin
			bank_clk_next = bsd_pkg::CTRL_RESET;
			db_clk_next   = bsd_pkg::CTRL_RESET;
			wr_pend_next  = 1'b0;
		end
		if (addr_phase && !hwrite && !rst) begin
			case (haddr[7:0])
				bsd_pkg::ADDR_CONFIG: begin
					rdata_next[bsd_pkg::CFG_MODULE_DETECT]      = mod_det_reg;
					rdata_next[bsd_pkg::CFG_DB_512K]            = db512_reg;
					rdata_next[bsd_pkg::CFG_FDB_SINGLE]         = fdb1_reg;
					rdata_next[bsd_pkg::CFG_BUF_LSB +: 2]       = buf_reg;
					rdata_next[bsd_pkg::CFG_EEPROM]             = eeprom_reg;
					rdata_next[bsd_pkg::CFG_MCT_AGING]          = mct_reg;
					rdata_next[bsd_pkg::CFG_FCB_AGING]          = fcb_reg;
					rdata_next[bsd_pkg::CFG_TIMEOUT_EN]         = tmo_en_reg;
					rdata_next[bsd_pkg::CFG_SELFTEST]           = loop_reg;
				end
				bsd_pkg::ADDR_STRAP_RAW: begin
					rdata_next[15:0]                            = td_cap_reg;
					rdata_next[bsd_pkg::RAW_PD_LSB +: 9]        = misc_cap_reg[8:0];
					rdata_next[bsd_pkg::RAW_BANK_A]             = misc_cap_reg[9];
					rdata_next[bsd_pkg::RAW_BANK_B]             = misc_cap_reg[10];
				end
				bsd_pkg::ADDR_BANK_CLK: rdata_next = bank_clk_next;
				bsd_pkg::ADDR_DB_CLK:   rdata_next = db_clk_next;
				bsd_pkg::ADDR_DELAY_ST: rdata_next = delay_status;
				default:                rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// Register bus state; zero wait states, always OKAY
	always_ff @(posedge clock) begin
		bank_clk_reg <= bank_clk_next;
		db_clk_reg   <= db_clk_next;
		wr_pend_reg  <= wr_pend_next;
		wr_addr_reg  <= wr_addr_next;
		hrdata       <= rdata_next;
		hreadyout    <= 1'b1;
		hresp        <= 1'b0;
	end

	// Clock delay selection per memory clock
	logic [8:0] reg_fields; // Register-held fields, bank A, bank B, database

	assign reg_fields = {db_clk_reg[bsd_pkg::DB_LSB +: 3],
		bank_clk_reg[bsd_pkg::BANK_B_LSB +: 3], bank_clk_reg[bsd_pkg::BANK_A_LSB +: 3]};
	assign delay_status = {17'h0_0000, clock_delay_from_reg, 3'h0, clock_delay_method};

	for (genvar i = 0; i < bsd_pkg::DELAY_FIELDS; i++) begin : g_delay
		logic [2:0] code;      // Captured tuning strap
		logic       from_next;
		logic [2:0] meth_next;

		assign code = misc_cap_reg[3*i +: 3];

		// Code zero follows the register; others are methods 0 to 6
		always_comb begin
			from_next = (code == bsd_pkg::DELAY_FROM_REG);
			meth_next = from_next ? reg_fields[3*i +: 3] : code - bsd_pkg::DELAY_ONE;
		end

		always_ff @(posedge clock) begin
			clock_delay_from_reg[i]      <= from_next;
			clock_delay_method[3*i +: 3] <= meth_next;
		end
	end

	// Millisecond tick divider
	logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic              tick_reg,     tick_next;

	always_comb begin
		tick_next     = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));
		tick_cnt_next = tick_next ? '0 : tick_cnt_reg + 1'b1;
		if (rst) begin
			tick_next     = 1'b0;
			tick_cnt_next = '0;
		end
	end

	always_ff @(posedge clock) begin
		tick_cnt_reg <= tick_cnt_next;
		tick_reg     <= tick_next;
	end

	// Per machine busy time, restarted whenever the machine is idle
	logic [SM_COUNT-1:0] expired;

	for (genvar s = 0; s < SM_COUNT; s++) begin : g_watch
		logic [CNT_W-1:0] busy_reg, busy_next;

		always_comb begin
			busy_next = busy_reg;
			if (rst || sm_idle[s] || !tmo_en_reg || expired[s]) begin
				busy_next = '0;
			end else if (tick_reg) begin
				busy_next = busy_reg + 1'b1;
			end
		end

		always_ff @(posedge clock) begin
			busy_reg <= busy_next;
		end

		assign expired[s] = (busy_reg == CNT_W'(TIMEOUT_TICKS));
	end

	// One-cycle reset request when any machine is stuck
	logic tmo_next;

	always_comb begin
		tmo_next = !rst && tmo_en_reg && (|expired);
	end

	always_ff @(posedge clock) begin
		timeout_reset <= tmo_next;
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_config_hold;
		!$past(rst) |-> $stable({td_cap_reg, misc_cap_reg, buf_reg, mod_det_reg, loop_reg});
	endproperty
	a_config_hold: assert property (p_config_hold) else $error("Configuration changed after reset");

	property p_module_detect;
		$fell(rst) |-> module_detect_en == !td_cap_reg[bsd_pkg::TD_MODULE_DETECT];
	endproperty
	a_module_detect: assert property (p_module_detect) else $error("Module detect decode wrong");

	property p_db_size;
		$fell(rst) |-> db_sram_512k == !td_cap_reg[bsd_pkg::TD_DB_SRAM_SIZE];
	endproperty
	a_db_size: assert property (p_db_size) else $error("Database size decode wrong");

	property p_fdb_depth;
		$fell(rst) |-> fdb_single_layer == td_cap_reg[bsd_pkg::TD_FDB_DEPTH];
	endproperty
	a_fdb_depth: assert property (p_fdb_depth) else $error("Depth decode wrong");

	property p_buffer_size;
		$fell(rst) |-> buffer_size == (!misc_cap_reg[9] ? bsd_pkg::BUF_512K :
			misc_cap_reg[10] ? bsd_pkg::BUF_2M : bsd_pkg::BUF_1M);
	endproperty
	a_buffer_size: assert property (p_buffer_size) else $error("Buffer size decode wrong");

	property p_flags;
		$fell(rst) |-> eeprom_present == !td_cap_reg[bsd_pkg::TD_EEPROM] &&
			multicast_control_table_aging_en == td_cap_reg[bsd_pkg::TD_MCT_AGING] &&
			frame_control_buffer_aging_en == td_cap_reg[bsd_pkg::TD_FCB_AGING] &&
			ram_selftest_loop == !td_cap_reg[bsd_pkg::TD_SELFTEST];
	endproperty
	a_flags: assert property (p_flags) else $error("Strap flag decode wrong");

	property p_timeout_gate;
		timeout_reset |-> timeout_reset_en ##1 !timeout_reset;
	endproperty
	a_timeout_gate: assert property (p_timeout_gate) else $error("Timeout reset while disabled");

	property p_led_drive;
		!$past(rst) |-> strap_td_oe && strap_td_out == $past(led_data);
	endproperty
	a_led_drive: assert property (p_led_drive) else $error("Shared pins not driving LEDs");

	property p_delay_a;
		!$past(rst) && !$past(rst, 2) |-> clock_delay_from_reg[0] == (misc_cap_reg[2:0] == 3'h0) &&
			(clock_delay_from_reg[0] || clock_delay_method[2:0] == misc_cap_reg[2:0] - 3'h1);
	endproperty
	a_delay_a: assert property (p_delay_a) else $error("Bank A delay selection wrong");

	property p_delay_db;
		clock_delay_from_reg[2] && !$past(rst) |-> clock_delay_method[8:6] == $past(db_clk_reg[2:0]);
	endproperty
	a_delay_db: assert property (p_delay_db) else $error("Database delay not from register");

	c_release:  cover property ($fell(rst));
	c_timeout:  cover property (timeout_reset);
	c_from_reg: cover property (clock_delay_from_reg[1] && $changed(clock_delay_method[5:3]));

endmodule : bsd_strap_decoder

// [bsd_strap_board.sv]
// Board strapping resistors on the shared and dedicated strap pins
module bsd_strap_board (
	input  wire logic [15:0] td_pull,      // Resistor level per shared pin
	input  wire logic [8:0]  pd_pull,      // Resistor level per tuning pin
	input  wire logic [1:0]  bank_pull,    // Bank A strap high, bank B low
	input  wire logic [15:0] strap_td_out, // Device LED drive
	input  wire logic        strap_td_oe,  // Device drives the shared pins
	output logic      [15:0] strap_td_in,
	output logic      [8:0]  strap_pd_in,
	output logic             bank_a_top_address_strap,
	output logic             bank_b_top_address_strap
);
	timeunit 1ns;
	timeprecision 1ps;
	// Resistors win only while the device leaves the shared pins alone
	assign strap_td_in              = strap_td_oe ? strap_td_out : td_pull;
	assign strap_pd_in              = pd_pull;
	assign bank_a_top_address_strap = bank_pull[1];
	assign bank_b_top_address_strap = bank_pull[0];
endmodule : bsd_strap_board

// [bsd_strap_decoder_test.sv]
module bsd_strap_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, hsel, hwrite, hready, hresp, hreadyout, strap_td_oe, timeout_reset;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, buffer_size, bank_pull;
	logic [2:0]  hsize, clock_delay_from_reg;
	logic [15:0] td_pull, led_data, strap_td_in, strap_td_out;
	logic [8:0]  pd_pull, strap_pd_in, clock_delay_method;
	logic [3:0]  sm_idle;
	logic        bank_a, bank_b, md, db, fdb, ee, multicast_control_table, fcb, toe, stl;
	int          failures, n_tests, cycles;
	// Small counts keep the watchdog run short
	bsd_strap_decoder #(.SM_COUNT(4), .TICK_CYCLES(4), .TIMEOUT_TICKS(3)) i_dut (
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .strap_td_in(strap_td_in), .strap_pd_in(strap_pd_in),
		.bank_a_top_address_strap(bank_a), .bank_b_top_address_strap(bank_b), .led_data(led_data),
		.strap_td_out(strap_td_out), .strap_td_oe(strap_td_oe), .sm_idle(sm_idle),
		.module_detect_en(md), .db_sram_512k(db), .fdb_single_layer(fdb), .buffer_size(buffer_size),
		.eeprom_present(ee), .multicast_control_table_aging_en(multicast_control_table), .frame_control_buffer_aging_en(fcb),
		.timeout_reset_en(toe), .ram_selftest_loop(stl), .clock_delay_from_reg(clock_delay_from_reg),
		.clock_delay_method(clock_delay_method), .timeout_reset(timeout_reset));
	bsd_strap_board i_board (.td_pull(td_pull), .pd_pull(pd_pull), .bank_pull(bank_pull),
		.strap_td_out(strap_td_out), .strap_td_oe(strap_td_oe), .strap_td_in(strap_td_in),
		.strap_pd_in(strap_pd_in), .bank_a_top_address_strap(bank_a), .bank_b_top_address_strap(bank_b));
	// Single slave: its ready is the bus ready
	assign hready = hreadyout;
	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (failures == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	// One whole-word AHB-Lite transfer, waiting on ready in both phases
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'b010;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0000_0000, "response not okay");
	endtask : ahb
	// Reset with given board straps, then check the shared pins change hands
	task automatic do_reset(input logic [15:0] td, input logic [8:0] pd, input logic [1:0] bk);
		td_pull   <= td;
		pd_pull   <= pd;
		bank_pull <= bk;
		led_data  <= ~led_data;
		rst       <= 1'b1;
		repeat (12) @(posedge clock);
		chk({15'h0, strap_td_oe, strap_td_out}, 32'h0000_0000, "pins driven in reset");
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk({15'h0, strap_td_oe, strap_td_out}, {15'h0, 1'b1, led_data}, "led drive");
	endtask : do_reset
	// Expected configuration word from the strap levels
	function automatic logic [31:0] exp_cfg(input logic [15:0] td, input logic [1:0] bk);
		logic [1:0] b;
		b = (bk == 2'b11) ? bsd_pkg::BUF_2M : (bk == 2'b10) ? bsd_pkg::BUF_1M : bsd_pkg::BUF_512K;
		exp_cfg = {21'h0, ~td[15], td[11], td[10], td[9], ~td[8], b, 1'b0, td[7], ~td[5], ~td[3]};
	endfunction : exp_cfg
	// Expected delay status: from-register flags and methods
	function automatic logic [31:0] exp_dly(input logic [8:0] pd, input logic [8:0] regs);
		logic [2:0] c;
		exp_dly = 32'h0000_0000;
		for (int i = 0; i < 3; i++) begin
			c = pd[3*i+:3];
			exp_dly[12+i] = (c == 3'h0);
			exp_dly[3*i+:3] = (c == 3'h0) ? regs[3*i+:3] : c - 3'h1;
		end
	endfunction : exp_dly
	// Every code of every strap field, captured and then held
	task automatic sc_decode();
		logic [15:0] td;
		logic [8:0]  pd;
		logic [1:0]  bk;
		logic [31:0] ob;
		for (int k = 0; k < 8; k++) begin
			td = {8{k[1:0]}};
			pd = {3'(k + 5), 3'(k + 3), 3'(k)};
			bk = k[2:1];
			do_reset(td, pd, bk);
			// Board levels flip after reset; decoded values must not follow
			td_pull   <= ~td;
			pd_pull   <= ~pd;
			bank_pull <= ~bk;
			repeat (5) @(posedge clock);
			ob = {21'h0, stl, toe, fcb, multicast_control_table, ee, buffer_size, 1'b0, fdb, db, md};
			chk(ob, exp_cfg(td, bk), "decoded outputs");
			chk({17'h0, clock_delay_from_reg, 3'h0, clock_delay_method}, exp_dly(pd, 9'h000), "delay");
			ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
			chk(rd, exp_cfg(td, bk), "config register");
			ahb(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
			chk(rd, {5'h0, bk[0], bk[1], pd, td}, "raw straps");
			ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
			chk(rd, exp_dly(pd, 9'h000), "delay status");
		end
	endtask : sc_decode
	// Code zero hands each delay to its control register field
	task automatic sc_reg();
		do_reset(16'hFFFF, 9'h000, 2'b11);
		chk({29'h0, clock_delay_from_reg}, 32'h0000_0007, "from reg flags");
		ahb(1'b1, 32'h0000_0008, 32'hFFFF_FF53, rd);
		ahb(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0053, "bank delay readback");
		ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFE, rd);
		ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0006, "database delay readback");
		chk({23'h0, clock_delay_method}, {23'h0, 3'h6, 3'h5, 3'h3}, "register methods");
		// Read-only and unmapped places
		ahb(1'b1, 32'h0000_0000, 32'h0000_0000, rd);
		ahb(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
		chk(rd, exp_cfg(16'hFFFF, 2'b11), "config written");
		ahb(1'b0, 32'h0000_0020, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000, "unmapped read");
	endtask : sc_reg
	// Stuck machine with the timeout enabled and disabled
	task automatic sc_watchdog(input logic [15:0] td, input logic exp);
		logic seen;
		int   waited;
		seen   = 1'b0;
		waited = 0;
		do_reset(td, 9'h1FF, 2'b00);
		sm_idle <= 4'b1101;
		for (int i = 0; i < 60 && !seen; i++) begin
			@(posedge clock);
			seen = timeout_reset;
			waited++;
		end
		sm_idle <= 4'b1111;
		chk({31'h0, seen}, {31'h0, exp}, "timeout pulse");
		// Three ticks of four cycles, plus tick phase and the pulse register
		if (exp) chk({31'h0, waited >= 9 && waited <= 20}, 32'h0000_0001, "timeout delay");
		@(posedge clock);
		chk({31'h0, timeout_reset}, 32'h0000_0000, "pulse length");
	endtask : sc_watchdog
	initial begin
		failures = 0;
		n_tests  = 0;
		cycles   = 0;
		rst      = 1'b1;
		hsel     = 1'b0;
		haddr    = 32'h0000_0000;
		htrans   = 2'b00;
		hwrite   = 1'b0;
		hsize    = 3'b010;
		hwdata   = 32'h0000_0000;
		led_data = 16'h3C5A;
		sm_idle  = 4'b1111;
		td_pull  = 16'hFFFF;
		pd_pull  = 9'h1FF;
		bank_pull = 2'b11;
		sc_decode();
		sc_reg();
		sc_watchdog(16'hFFFF, 1'b1);
		sc_watchdog(16'hF7FF, 1'b0);
		wrap_up();
	end
endmodule : bsd_strap_decoder_test
